// File: core/sdrcp_core.sv
// Memory-side command decode, bank state, bursts and data lanes
`timescale 1ns/1ps
module sdrcp_core (
  input wire logic i_core_clk, // System clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic i_clk_gate, // Clock gate, high keeps clock active
  input wire logic i_page_reduced, // Reduced page size strap
  input wire logic i_chip_sel_n, // Chip select
  input wire logic i_row_strobe_n, // Row strobe
  input wire logic i_col_strobe_n, // Column strobe
  input wire logic i_write_strobe_n, // Write strobe
  input wire logic [sdrcp_pkg::BANK_W-1:0] i_bank_select, // Bank select
  input wire logic [sdrcp_pkg::ADDR_W-1:0] i_addr, // Address bus
  input wire logic [sdrcp_pkg::BYTES-1:0] i_byte_mask, // Byte masks
  input wire logic [sdrcp_pkg::DQ_W-1:0] i_dq, // Data bus in
  output logic [sdrcp_pkg::DQ_W-1:0] o_dq, // Data bus out
  output logic [sdrcp_pkg::BYTES-1:0] o_dq_oe, // Per-byte drive enable
  output logic o_rx_enable, // Input receivers on
  output logic [sdrcp_pkg::BANKS-1:0] o_bank_open, // Row open per bank
  output logic [sdrcp_pkg::ADDR_W-1:0] o_mode_reg, // Mode register
  output sdrcp_pkg::sdrcp_pwr_t o_pwr_state // Power state
);
  import sdrcp_pkg::*;

  typedef struct packed {
    sdrcp_pwr_t pwr;
    logic [BANKS-1:0] open;
    logic [BANKS-1:0][ADDR_W-1:0] row;
    logic [ADDR_W-1:0] mode;
    logic bact;
    logic bwr;
    logic full;
    logic ap;
    logic [BANK_W-1:0] bbank;
    logic [COL_W-1:0] col;
    logic [3:0] left;
    logic rv;
    logic [BYTES-1:0] mask;
    logic [BYTES-1:0] oe;
  } sdrcp_state_t;

  sdrcp_state_t st_q;
  sdrcp_state_t st_d;
  logic [3:0] cmd;
  logic live;
  logic take;
  logic cl3;
  logic [2:0] bl;
  logic [3:0] bl_len;
  logic [COL_W-1:0] col_mask;
  logic [COL_W-1:0] wrap;
  logic [COL_W-1:0] col_cmd;
  logic [COL_W-1:0] col_next;
  logic [ADDR_W-1:0] row_mask;
  logic rw_go;
  logic rv_now;
  logic wr_now;
  logic [RAM_AW-1:0] ram_raddr;
  logic [RAM_AW-1:0] ram_waddr;
  logic [DQ_W-1:0] ram_dout;
  logic [DQ_W-1:0] pipe_dout;
  logic [BYTES-1:0] ram_we;

  assign cmd = {i_chip_sel_n, i_row_strobe_n, i_col_strobe_n, i_write_strobe_n};
  assign live = (st_q.pwr == PWR_RUN) && i_clk_gate;
  assign take = live && !i_chip_sel_n;
  assign bl = st_q.mode[BL_LSB +: 3];
  assign cl3 = (st_q.mode[CL_LSB +: 3] == CL_THREE);
  assign bl_len = 4'h1 << bl[1:0];
  // column and row widths per page option
  assign col_mask = i_page_reduced ? COL_MASK_RED : COL_MASK_STD;
  assign row_mask = i_page_reduced ? ROW_MASK_RED : ROW_MASK_STD;
  assign col_cmd = i_addr[COL_W-1:0] & col_mask;
  assign wrap = (bl == BL_FULL) ? col_mask : {6'h00, bl_len - 4'h1};
  assign rw_go = take && (cmd == CMD_RD || cmd == CMD_WR) && st_q.open[i_bank_select];
  assign col_next = (st_q.col & ~wrap) | ((st_q.col + 10'h001) & wrap);
  assign rv_now = live && st_q.bact && !st_q.bwr;
  assign wr_now = (rw_go && cmd == CMD_WR)
    || (live && st_q.bact && st_q.bwr && !rw_go && !(take && cmd == CMD_BST));
  assign ram_raddr = {st_q.bbank, st_q.row[st_q.bbank][1:0], st_q.col[3:0]};
  assign ram_waddr = (rw_go && cmd == CMD_WR)
    ? {i_bank_select, st_q.row[i_bank_select][1:0], col_cmd[3:0]} : ram_raddr;
  assign ram_we = {BYTES{wr_now}} & ~i_byte_mask;

  // byte lane n under mask n
  genvar gb;
  generate
    for (gb = 0; gb < BYTES; gb++)
    begin : g_lane
      sdrcp_byte_ram #(.AW(RAM_AW)) u_ram (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_we(ram_we[gb]),
        .i_waddr(ram_waddr),
        .i_wdata(i_dq[8*gb +: 8]),
        .i_raddr(ram_raddr),
        .o_rdata(ram_dout[8*gb +: 8])
      );
    end
  endgenerate

  sdrcp_pipe #(.W(DQ_W)) u_cl_pipe (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_d(ram_dout),
    .o_q(pipe_dout)
  );

  always_comb
  begin
    st_d = st_q;
    // mask captured, applied one stage later
    st_d.mask = i_byte_mask;
    st_d.rv = rv_now;
    st_d.oe = {BYTES{cl3 ? st_q.rv : rv_now}} & ~st_q.mask;
    if (live && st_q.bact)
    begin
      if (!st_q.full && st_q.left == 4'h1)
      begin
        st_d.bact = 1'b0;
        if (st_q.ap)
          st_d.open[st_q.bbank] = 1'b0;
      end
      else
      begin
        st_d.col = col_next;
        st_d.left = st_q.left - 4'h1;
      end
    end
    if (take)
    begin
      case (cmd)
        CMD_ACT:
        begin
          st_d.open[i_bank_select] = 1'b1;
          st_d.row[i_bank_select] = i_addr & row_mask;
        end
        CMD_RD, CMD_WR:
        begin
          if (rw_go)
          begin
            st_d.bbank = i_bank_select;
            st_d.full = (bl == BL_FULL);
            st_d.bwr = (cmd == CMD_WR);
            st_d.ap = i_addr[AP_BIT];
            if (cmd == CMD_RD)
            begin
              st_d.bact = 1'b1;
              st_d.col = col_cmd;
              st_d.left = bl_len;
            end
            else
            begin
              st_d.bact = (bl_len != 4'h1) || (bl == BL_FULL);
              st_d.col = (col_cmd & ~wrap) | ((col_cmd + 10'h001) & wrap);
              st_d.left = bl_len - 4'h1;
              if (!st_d.bact && i_addr[AP_BIT])
                st_d.open[i_bank_select] = 1'b0;
            end
          end
        end
        CMD_PRE:
        begin
          if (i_addr[AP_BIT])
            st_d.open = '0;
          else
            st_d.open[i_bank_select] = 1'b0;
          if (i_addr[AP_BIT] || i_bank_select == st_q.bbank)
            st_d.bact = 1'b0;
        end
        CMD_LMR:
        begin
          if (st_q.open == '0 && !st_q.bact)
            st_d.mode = i_addr;
        end
        CMD_BST:
          st_d.bact = 1'b0;
        default:
          st_d.bact = st_d.bact;
      endcase
    end
    case (st_q.pwr)
      PWR_RUN:
      begin
        if (!i_clk_gate)
        begin
          if (!i_chip_sel_n && cmd == CMD_REF && st_q.open == '0)
            st_d.pwr = PWR_SREF;
          else if (!i_chip_sel_n && cmd == CMD_BST && st_q.open == '0)
            st_d.pwr = PWR_DPD;
          else if (st_q.bact)
            st_d.pwr = PWR_SUSP;
          else if (st_q.open != '0)
            st_d.pwr = PWR_APD;
          else
            st_d.pwr = PWR_PPD;
        end
      end
      PWR_PPD, PWR_APD, PWR_SREF, PWR_DPD, PWR_SUSP:
      begin
        if (i_clk_gate)
          st_d.pwr = PWR_RUN;
      end
      default:
        st_d.pwr = PWR_RUN;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q <= '0;
      st_q.pwr <= PWR_RUN;
      st_q.mode <= MODE_RST;
    end
    else
      st_q <= st_d;
  end

  // receivers off while powered down, gate watched combinationally
  assign o_rx_enable = !(st_q.pwr inside {PWR_PPD, PWR_APD, PWR_SREF, PWR_DPD}) || i_clk_gate;
  assign o_dq = cl3 ? pipe_dout : ram_dout;
  assign o_dq_oe = st_q.oe;
  assign o_bank_open = st_q.open;
  assign o_mode_reg = st_q.mode;
  assign o_pwr_state = st_q.pwr;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);

  AST_CS_MASK: assert property (live && i_chip_sel_n |=> $stable(o_mode_reg))
    else $error("mode changed while deselected");
  AST_MASK_HIZ: assert property (i_byte_mask != '0 |-> ##2 (o_dq_oe & $past(i_byte_mask, 2)) == '0)
    else $error("masked read byte still driven");
  AST_LMR: assert property (take && cmd == CMD_LMR && o_bank_open == '0 && !st_q.bact
    |=> o_mode_reg == $past(i_addr))
    else $error("mode register not loaded");
  AST_PRE_ALL: assert property (take && cmd == CMD_PRE && i_addr[AP_BIT] |=> o_bank_open == '0)
    else $error("all-bank precharge left a bank open");
  AST_PRE_ONE: assert property (take && cmd == CMD_PRE && !i_addr[AP_BIT]
    |=> !o_bank_open[$past(i_bank_select)])
    else $error("selected bank not precharged");
  AST_ACT: assert property (take && cmd == CMD_ACT |=> o_bank_open[$past(i_bank_select)])
    else $error("activate did not open bank");
  AST_RX_OFF: assert property (o_pwr_state == PWR_SREF && !i_clk_gate |-> !o_rx_enable)
    else $error("receivers on in self refresh");
  AST_READ_LAT: assert property (rw_go && cmd == CMD_RD && !cl3 && i_byte_mask == '0 ##1 live
    |-> ##1 o_dq_oe == 4'hf)
    else $error("read data not driven at latency two");
  AST_CL3_LAT: assert property (rw_go && cmd == CMD_RD && cl3 ##1 live && i_byte_mask == '0
    |-> ##2 o_dq_oe == 4'hf)
    else $error("read data not driven at latency three");
  AST_SUSP: assert property (st_q.pwr == PWR_RUN && st_q.bact && !i_clk_gate && i_chip_sel_n
    |=> o_pwr_state == PWR_SUSP)
    else $error("no clock suspend during burst");
  AST_GATE_HOLD: assert property (!live |=> $stable(o_bank_open))
    else $error("bank state changed with clock gated");
  AST_EXIT: assert property (o_pwr_state != PWR_RUN && i_clk_gate |=> o_pwr_state == PWR_RUN)
    else $error("clock gate high did not leave low-power state");

  COV_READ: cover property (rw_go && cmd == CMD_RD ##2 o_dq_oe != '0);
  COV_WRITE: cover property (rw_go && cmd == CMD_WR ##1 wr_now);
  COV_SREF: cover property (o_pwr_state == PWR_SREF ##1 o_pwr_state == PWR_RUN);
  COV_DPD: cover property (o_pwr_state == PWR_DPD);
  COV_SUSP: cover property (o_pwr_state == PWR_SUSP ##1 o_pwr_state == PWR_RUN);
endmodule : sdrcp_core

// File: core/sdrcp_pkg.sv
// Constants and types for the memory-side command pin interface
package sdrcp_pkg;
  localparam int DQ_W = 32;
  localparam int BYTES = 4;
  localparam int ADDR_W = 14;
  localparam int COL_W = 10;
  localparam int BANK_W = 2;
  localparam int BANKS = 4;
  localparam int RAM_AW = 8;
  // Array organisation per configuration
  localparam int ROWS_X16 = 8192;
  localparam int COLS_X16 = 1024;
  localparam int ROWS_X32 = 8192;
  localparam int COLS_X32 = 512;
  localparam int ROWS_X32_RED = 16384;
  localparam int COLS_X32_RED = 256;
  localparam logic [ADDR_W-1:0] ROW_MASK_STD = 14'h1fff;
  localparam logic [ADDR_W-1:0] ROW_MASK_RED = 14'h3fff;
  localparam logic [COL_W-1:0] COL_MASK_X16 = 10'h3ff;
  localparam logic [COL_W-1:0] COL_MASK_STD = 10'h1ff;
  localparam logic [COL_W-1:0] COL_MASK_RED = 10'h0ff;
  localparam int AP_BIT = 10;
  // Mode register fields
  localparam int BL_LSB = 0;
  localparam int CL_LSB = 4;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_THREE = 3'h3;
  localparam logic [ADDR_W-1:0] MODE_RST = 14'h0000;
  // Command codes: chip select, row, column, write strobes
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  typedef enum logic [2:0] {PWR_RUN, PWR_PPD, PWR_APD, PWR_SREF, PWR_DPD, PWR_SUSP} sdrcp_pwr_t;
endpackage : sdrcp_pkg

// File: core/sdrcp_pipe.sv
// One register stage for read data
`timescale 1ns/1ps
module sdrcp_pipe #(
  parameter int W = 32
) (
  input wire logic i_core_clk, // Clock
  input wire logic i_arst_n, // Async reset
  input wire logic [W-1:0] i_d, // Stage input
  output logic [W-1:0] o_q // Stage output
);
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_q <= '0;
    else
      o_q <= i_d;
  end
endmodule : sdrcp_pipe

// File: core/sdrcp_byte_ram.sv
// One byte lane of the storage array
`timescale 1ns/1ps
module sdrcp_byte_ram #(
  parameter int AW = 8
) (
  input wire logic i_core_clk, // Clock
  input wire logic i_arst_n, // Async reset
  input wire logic i_we, // Write this byte
  input wire logic [AW-1:0] i_waddr, // Write index
  input wire logic [7:0] i_wdata, // Write byte
  input wire logic [AW-1:0] i_raddr, // Read index
  output logic [7:0] o_rdata // Registered read byte
);
  logic [7:0] mem [0:(1<<AW)-1];
  always_ff @(posedge i_core_clk)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
  end
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= 8'h00;
    else
      o_rdata <= mem[i_raddr];
  end
endmodule : sdrcp_byte_ram

// File: tb/sdrcp_ctrl_model.sv
// Memory controller model driving the command and data pins
`timescale 1ns/1ps
module sdrcp_ctrl_model (
  input wire logic i_core_clk, // System clock
  output logic o_clk_gate, // Clock gate
  output logic o_chip_sel_n, // Chip select
  output logic o_row_strobe_n, // Row strobe
  output logic o_col_strobe_n, // Column strobe
  output logic o_write_strobe_n, // Write strobe
  output logic [sdrcp_pkg::BANK_W-1:0] o_bank_select, // Bank select
  output logic [sdrcp_pkg::ADDR_W-1:0] o_addr, // Address bus
  output logic [sdrcp_pkg::BYTES-1:0] o_byte_mask, // Byte masks
  output logic [sdrcp_pkg::DQ_W-1:0] o_dq // Write data
);
  import sdrcp_pkg::*;
  initial
  begin
    o_clk_gate = 1'b1;
    {o_chip_sel_n, o_row_strobe_n, o_col_strobe_n, o_write_strobe_n} = 4'hf;
    o_bank_select = 2'h0;
    o_addr = 14'h0000;
    o_byte_mask = 4'h0;
    o_dq = 32'h0000_0000;
  end
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a, input logic [3:0] m,
    input logic [31:0] d, input logic g);
    @(negedge i_core_clk);
    {o_chip_sel_n, o_row_strobe_n, o_col_strobe_n, o_write_strobe_n} = c;
    o_bank_select = b;
    o_addr = a;
    o_byte_mask = m;
    o_dq = d;
    o_clk_gate = g;
  endtask : cmd
  task automatic idle(input logic g);
    cmd(4'hf, 2'h0, 14'h0000, 4'h0, ~o_dq, g);
  endtask : idle
endmodule : sdrcp_ctrl_model

// File: tb/tb_sdrcp_core.sv
// Testbench for the memory-side command pin interface
`timescale 1ns/1ps
module tb_sdrcp_core;
  import sdrcp_pkg::*;
  logic core_clk;
  logic arst_n;
  logic clk_gate, cs_n, ras_n, cas_n, we_n;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr, mode_reg;
  logic [BYTES-1:0] mask, dq_oe;
  logic [DQ_W-1:0] dq_w, dq_r;
  logic rx_en;
  logic [BANKS-1:0] bank_open;
  sdrcp_pwr_t pwr;
  int mismatches = 0;
  int n_tests = 0;
  sdrcp_ctrl_model u_sdrcp_ctrl_model (.i_core_clk(core_clk), .o_clk_gate(clk_gate), .o_chip_sel_n(cs_n),
    .o_row_strobe_n(ras_n), .o_col_strobe_n(cas_n), .o_write_strobe_n(we_n), .o_bank_select(ba),
    .o_addr(addr), .o_byte_mask(mask), .o_dq(dq_w));
  sdrcp_core u_sdrcp_core (.i_core_clk(core_clk), .i_arst_n(arst_n), .i_clk_gate(clk_gate),
    .i_page_reduced(1'b0), .i_chip_sel_n(cs_n), .i_row_strobe_n(ras_n), .i_col_strobe_n(cas_n),
    .i_write_strobe_n(we_n), .i_bank_select(ba), .i_addr(addr), .i_byte_mask(mask), .i_dq(dq_w),
    .o_dq(dq_r), .o_dq_oe(dq_oe), .o_rx_enable(rx_en), .o_bank_open(bank_open), .o_mode_reg(mode_reg),
    .o_pwr_state(pwr));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a, input logic [3:0] m,
    input logic [31:0] d);
    u_sdrcp_ctrl_model.cmd(c, b, a, m, d, 1'b1);
  endtask : cmd
  task automatic nop();
    u_sdrcp_ctrl_model.idle(1'b1);
    #1;
  endtask : nop
  task automatic t_reset();
    chk("bank_open", 32'h0, bank_open);
    chk("mode_reg", 32'h0, mode_reg);
    chk("pwr", PWR_RUN, pwr);
    chk("dq_oe", 32'h0, dq_oe);
    chk("rx_en", 32'h1, rx_en);
    $display("test reset done");
  endtask : t_reset
  task automatic t_mode();
    cmd(4'h8, 2'h0, 14'h0013, 4'h0, 32'h0);
    nop();
    chk("mode_deselected", 32'h0, mode_reg);
    cmd(CMD_LMR, 2'h0, 14'h0021, 4'h0, 32'h0);
    nop();
    chk("mode_reg", 32'h0021, mode_reg);
    $display("test mode done");
  endtask : t_mode
  task automatic t_data();
    cmd(4'hb, 2'h2, 14'h0000, 4'h0, 32'h0);
    nop();
    chk("act_deselected", 32'h0, bank_open);
    cmd(CMD_ACT, 2'h2, 14'h0000, 4'h0, 32'h0);
    nop();
    chk("act_bank2", 32'h4, bank_open);
    cmd(CMD_WR, 2'h2, 14'h0004, 4'h0, 32'h11223344);
    cmd(4'hf, 2'h0, 14'h0000, 4'h0, 32'h55667788);
    cmd(CMD_WR, 2'h2, 14'h0004, 4'h2, 32'haabbccdd);
    cmd(4'hf, 2'h0, 14'h0000, 4'h0, 32'h01020304);
    cmd(CMD_RD, 2'h2, 14'h0004, 4'h8, 32'h0);
    nop();
    nop();
    chk("rd_word0", 32'haabb33dd, dq_r);
    chk("rd_oe0", 32'h7, dq_oe);
    nop();
    chk("rd_word1", 32'h01020304, dq_r);
    chk("rd_oe1", 32'hf, dq_oe);
    nop();
    chk("rd_oe_end", 32'h0, dq_oe);
    cmd(CMD_RD, 2'h2, 14'h0404, 4'h0, 32'h0);
    repeat (4) nop();
    chk("auto_pre", 32'h0, bank_open);
    $display("test data done");
  endtask : t_data
  task automatic t_precharge();
    cmd(CMD_ACT, 2'h0, 14'h0001, 4'h0, 32'h0);
    cmd(CMD_ACT, 2'h1, 14'h0002, 4'h0, 32'h0);
    nop();
    chk("two_open", 32'h3, bank_open);
    cmd(CMD_PRE, 2'h1, 14'h0000, 4'h0, 32'h0);
    nop();
    chk("pre_one", 32'h1, bank_open);
    cmd(CMD_PRE, 2'h1, 14'h0400, 4'h0, 32'h0);
    nop();
    chk("pre_all", 32'h0, bank_open);
    $display("test precharge done");
  endtask : t_precharge
  task automatic t_cl3();
    cmd(CMD_LMR, 2'h0, 14'h0031, 4'h0, 32'h0);
    cmd(CMD_ACT, 2'h1, 14'h0000, 4'h0, 32'h0);
    cmd(CMD_WR, 2'h1, 14'h0008, 4'h0, 32'hcafe0001);
    cmd(4'hf, 2'h0, 14'h0000, 4'h0, 32'hcafe0002);
    cmd(CMD_RD, 2'h1, 14'h0008, 4'h0, 32'h0);
    nop();
    nop();
    chk("cl3_oe_early", 32'h0, dq_oe);
    nop();
    chk("cl3_word0", 32'hcafe0001, dq_r);
    chk("cl3_oe0", 32'hf, dq_oe);
    nop();
    chk("cl3_word1", 32'hcafe0002, dq_r);
    nop();
    chk("cl3_oe_end", 32'h0, dq_oe);
    cmd(CMD_PRE, 2'h0, 14'h0400, 4'h0, 32'h0);
    cmd(CMD_LMR, 2'h0, 14'h0021, 4'h0, 32'h0);
    nop();
    chk("cl2_restored", 32'h0021, mode_reg);
    $display("test latency three done");
  endtask : t_cl3
  task automatic t_susp();
    cmd(CMD_ACT, 2'h3, 14'h0000, 4'h0, 32'h0);
    cmd(CMD_WR, 2'h3, 14'h0000, 4'h0, 32'hdead0001);
    cmd(4'hf, 2'h0, 14'h0000, 4'h0, 32'hdead0002);
    cmd(CMD_RD, 2'h3, 14'h0000, 4'h0, 32'h0);
    u_sdrcp_ctrl_model.cmd(4'hf, 2'h0, 14'h0000, 4'h0, 32'h0, 1'b0);
    nop();
    chk("susp_state", PWR_SUSP, pwr);
    chk("susp_oe", 32'h0, dq_oe);
    chk("susp_rx", 32'h1, rx_en);
    nop();
    nop();
    chk("susp_word0", 32'hdead0001, dq_r);
    chk("susp_oe0", 32'hf, dq_oe);
    nop();
    chk("susp_word1", 32'hdead0002, dq_r);
    nop();
    chk("susp_oe_end", 32'h0, dq_oe);
    $display("test clock suspend done");
  endtask : t_susp
  task automatic t_stop();
    cmd(CMD_PRE, 2'h0, 14'h0400, 4'h0, 32'h0);
    cmd(CMD_LMR, 2'h0, 14'h0027, 4'h0, 32'h0);
    cmd(CMD_ACT, 2'h3, 14'h0000, 4'h0, 32'h0);
    cmd(CMD_RD, 2'h3, 14'h0000, 4'h0, 32'h0);
    cmd(CMD_BST, 2'h0, 14'h0000, 4'h0, 32'h0);
    nop();
    chk("stop_oe0", 32'hf, dq_oe);
    chk("stop_word0", 32'hdead0001, dq_r);
    nop();
    chk("stop_oe_end", 32'h0, dq_oe);
    cmd(CMD_PRE, 2'h3, 14'h0000, 4'h0, 32'h0);
    cmd(CMD_LMR, 2'h0, 14'h0021, 4'h0, 32'h0);
    nop();
    chk("stop_bank", 32'h0, bank_open);
    chk("stop_mode", 32'h0021, mode_reg);
    $display("test burst stop done");
  endtask : t_stop
  task automatic t_pwr(input logic [3:0] c, input sdrcp_pwr_t e);
    u_sdrcp_ctrl_model.cmd(c, 2'h0, 14'h0000, 4'h0, 32'h0, 1'b0);
    u_sdrcp_ctrl_model.idle(1'b0);
    #1;
    chk("pwr_low", e, pwr);
    chk("rx_low", 32'h0, rx_en);
    nop();
    nop();
    chk("pwr_exit", PWR_RUN, pwr);
    chk("rx_high", 32'h1, rx_en);
    $display("test power %0d done", e);
  endtask : t_pwr
  initial
  begin
    arst_n = 1'b0;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    #1;
    t_reset();
    t_mode();
    t_data();
    t_precharge();
    t_cl3();
    t_susp();
    t_stop();
    t_pwr(CMD_REF, PWR_SREF);
    t_pwr(CMD_BST, PWR_DPD);
    t_pwr(4'hf, PWR_PPD);
    cmd(CMD_ACT, 2'h0, 14'h0000, 4'h0, 32'h0);
    t_pwr(4'hf, PWR_APD);
    finish_test();
  end
  initial
  begin
    #1000000;
    mismatches++;
    finish_test();
  end
endmodule : tb_sdrcp_core
